// *** hw/lsu_order_defines.vh ***
// constants for the load/store ordering unit
`ifndef LSU_ORDER_DEFINES_VH
`define LSU_ORDER_DEFINES_VH
`define PA_WIDTH        40
`define VA_WIDTH        48
`define PA_IO_BIT       39
`define PA_ALIAS_HI     38
`define PA_ALIAS_LO     37
`define MM_FIELD_VALUE  2'h0
`define OP_LOAD         3'h0
`define OP_STORE        3'h1
`define OP_ATOMIC       3'h2
`define OP_FETCH        3'h3
`define OP_BARRIER      3'h4
`define BAR_LOAD_TO_LOAD_BARRIER    0
`define BAR_STORE_TO_LOAD_BARRIER   1
`define BAR_LOADSTORE   2
`define BAR_STORESTORE  3
`define BAR_ISSUE       4
`define MEM_TOP_DEFAULT 37'h0FFFFFFFFF
`endif

// *** hw/store_buffer.v ***
// in-order store buffer with youngest-match load forwarding
`timescale 1ns/1ps
`include "lsu_order_defines.vh"
module store_buffer #(
  parameter DEPTH = 8,
  parameter AW    = 3,
  parameter DW    = 64
) (
  input  wire                 clock,
  input  wire                 nrst,
  input  wire                 push,
  input  wire [`PA_WIDTH-1:0] push_addr,
  input  wire [DW-1:0]        push_data,
  input  wire                 push_io,
  input  wire                 pop,
  input  wire [`PA_WIDTH-1:0] look_addr,
  output reg                  look_hit,
  output reg  [DW-1:0]        look_data,
  output wire                 full,
  output wire                 empty,
  output wire [`PA_WIDTH-1:0] head_addr,
  output wire [DW-1:0]        head_data,
  output wire                 head_io,
  output wire                 any_io
);
  reg [`PA_WIDTH-1:0] addr_mem [0:DEPTH-1];
  reg [DW-1:0]        data_mem [0:DEPTH-1];
  reg [DEPTH-1:0]     valid;
  reg [DEPTH-1:0]     io;
  reg [AW-1:0]        rd_ptr;
  reg [AW-1:0]        wr_ptr;
  reg [AW:0]          count;
  integer             i;
  reg [AW-1:0]        idx;

  assign full      = (count == DEPTH[AW:0]);
  assign empty     = (count == {(AW+1){1'b0}});
  assign head_addr = addr_mem[rd_ptr];
  assign head_data = data_mem[rd_ptr];
  assign head_io   = io[rd_ptr];
  assign any_io    = |(io & valid);

  // scan oldest to youngest so the youngest match wins
  always @* begin
    look_hit  = 1'b0;
    look_data = {DW{1'b0}};
    idx       = rd_ptr;
    for (i = 0; i < DEPTH; i = i + 1) begin
      idx = rd_ptr + i[AW-1:0];
      if (valid[idx] && addr_mem[idx] == look_addr) begin
        look_hit  = 1'b1;
        look_data = data_mem[idx];
      end
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      valid  <= {DEPTH{1'b0}};
      io     <= {DEPTH{1'b0}};
      rd_ptr <= {AW{1'b0}};
      wr_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push && !full) begin
        addr_mem[wr_ptr] <= push_addr;
        data_mem[wr_ptr] <= push_data;
        io[wr_ptr]       <= push_io;
        valid[wr_ptr]    <= 1'b1;
        wr_ptr           <= wr_ptr + 1'b1;
      end
      if (pop && !empty) begin
        valid[rd_ptr] <= 1'b0;
        rd_ptr        <= rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push && !full}
                     - {{AW{1'b0}}, pop && !empty};
    end
  end
endmodule

// *** hw/load_store_ordering_unit.v ***
// load/store ordering and physical address classification unit
//
// Design decisions made here: the address map.
`timescale 1ns/1ps
`include "lsu_order_defines.vh"
module load_store_ordering_unit #(
  parameter SB_DEPTH = 8,
  parameter SB_AW    = 3,
  parameter DW       = 64,
  parameter [36:0] MEM_TOP = `MEM_TOP_DEFAULT
) (
  input  wire                 clock,
  input  wire                 nrst,
  // request from the core pipeline
  input  wire                 req_valid,
  output wire                 req_ready,
  input  wire [2:0]           req_op,
  input  wire [`VA_WIDTH-1:0] req_va,
  input  wire [`PA_WIDTH-1:0] req_pa,
  input  wire [DW-1:0]        req_wdata,
  input  wire                 req_relaxed,
  input  wire                 req_side_effect,
  input  wire [4:0]           req_bar_mask,
  output reg                  rsp_valid,
  output reg  [DW-1:0]        rsp_data,
  output reg                  load_bus_error_trap,
  output reg                  fetch_bus_error_trap,
  output reg                  atomic_space_trap,
  output wire [1:0]           memory_model_field,
  // toward the cache crossbar and i/o bridge
  output reg                  mem_valid,
  input  wire                 mem_ready,
  output reg                  mem_write,
  output reg  [`PA_WIDTH-1:0] mem_addr,
  output reg  [DW-1:0]        mem_wdata,
  output reg                  mem_io,
  input  wire                 mem_done,
  input  wire                 mem_visible,
  input  wire [DW-1:0]        mem_rdata,
  input  wire                 mem_error
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_LOAD = 4'h2;
  localparam [3:0] ST_WAIT = 4'h4;
  localparam [3:0] ST_BAR  = 4'h8;

  reg  [3:0]           state;
  reg  [3:0]           next_state;
  reg  [`PA_WIDTH-1:0] ld_addr;
  reg                  ld_fetch;
  reg                  ld_atomic;
  reg  [DW-1:0]        ld_wdata;
  reg  [4:0]           bar_mask;
  reg                  st_busy;
  reg                  nc_pending;
  reg                  io_pending;
  wire                 sb_full;
  wire                 sb_empty;
  wire                 sb_hit;
  wire [DW-1:0]        sb_data;
  wire [`PA_WIDTH-1:0] sb_head_addr;
  wire [DW-1:0]        sb_head_data;
  wire                 sb_head_io;
  wire                 sb_any_io;
  wire [`PA_WIDTH-1:0] eff_pa;
  wire                 is_io;
  wire                 exists;
  wire                 op_ld;
  wire                 op_st;
  wire                 op_at;
  wire                 op_fe;
  wire                 op_bar;
  wire                 take;
  wire                 st_drained;
  wire                 st_push;
  wire                 st_issue;
  wire                 ld_block;
  wire                 sb_pop;
  wire                 fwd;
  wire                 ld_finish;

  // the model field is hard wired
  assign memory_model_field = `MM_FIELD_VALUE;

  // class from bit 39 only; side effect bit unused here
  assign is_io = req_pa[`PA_IO_BIT];

  // alias bits cleared on memory requests; widths
  assign eff_pa = is_io ? req_pa :
    {req_pa[`PA_WIDTH-1:`PA_ALIAS_HI+1], 2'b00,
     req_pa[`PA_ALIAS_LO-1:0]};

  // i/o existence is judged by the bridge through mem_error
  assign exists = is_io | (eff_pa[36:0] <= MEM_TOP);

  assign op_ld  = req_op == `OP_LOAD;
  assign op_st  = req_op == `OP_STORE;
  assign op_at  = req_op == `OP_ATOMIC;
  assign op_fe  = req_op == `OP_FETCH;
  assign op_bar = req_op == `OP_BARRIER;

  assign st_drained = sb_empty && !st_busy;

  // a load served from the store buffer never uses the port
  assign fwd = op_ld && sb_hit && !is_io;

  // an atomic ends when its store half is visible
  assign ld_finish = mem_done || (ld_atomic && mem_visible);

  // a loaded store-to-load barrier holds later loads; io waits
  // atomic also waits for all older stores, being a store too
  // relaxed io waits on queued io stores and on any store in flight
  // port held by a store, or a store waiting for it, holds port loads
  assign ld_block = (op_at && !st_drained)
                  || (is_io && !req_relaxed && !st_drained)
                  || (is_io && req_relaxed && sb_any_io)
                  || (is_io && st_busy)
                  || (!fwd && (mem_valid || (!sb_empty && !st_busy)));

  // stores queue in order; loads finish before store accept
  assign st_push = take && op_st && exists;

  assign req_ready = (state == ST_IDLE) &&
                     !(op_st && sb_full) &&
                     !((op_ld || op_fe || op_at) && ld_block);
  assign take = req_valid && req_ready;

  // one store in flight; next leaves only when visible
  // relaxed stores still use this single drain path
  // no store leaves while a load is outstanding
  assign st_issue = !sb_empty && !st_busy
                  && (state == ST_IDLE || state == ST_BAR)
                  && !(mem_valid && !mem_write);
  assign sb_pop   = st_issue && mem_ready;

  store_buffer #(
    .DEPTH (SB_DEPTH),
    .AW    (SB_AW),
    .DW    (DW)
  ) u_sb (
    .clock     (clock),
    .nrst      (nrst),
    .push      (st_push),
    .push_addr (eff_pa),
    .push_data (req_wdata),
    .push_io   (is_io),
    .pop       (sb_pop),
    .look_addr (eff_pa),
    .look_hit  (sb_hit),
    .look_data (sb_data),
    .full      (sb_full),
    .empty     (sb_empty),
    .head_addr (sb_head_addr),
    .head_data (sb_head_data),
    .head_io   (sb_head_io),
    .any_io    (sb_any_io)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take && op_bar)
          next_state = ST_BAR;
        else if (take && (op_ld || op_fe || op_at) && exists &&
                 !fwd && !(op_at && is_io))
          next_state = ST_LOAD;
      end
      ST_LOAD: begin
        if (mem_ready)
          next_state = ST_WAIT;
      end
      ST_WAIT: begin
        // next load accepted only after this one completes
        if (ld_finish)
          next_state = ST_IDLE;
      end
      ST_BAR: begin
        // wait until masked classes have drained
        if (!(bar_mask[`BAR_STORE_TO_LOAD_BARRIER] || bar_mask[`BAR_STORESTORE] ||
              bar_mask[`BAR_ISSUE]) || st_drained)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state                <= ST_IDLE;
      ld_addr              <= {`PA_WIDTH{1'b0}};
      ld_fetch             <= 1'b0;
      ld_atomic            <= 1'b0;
      ld_wdata             <= {DW{1'b0}};
      bar_mask             <= 5'h00;
      st_busy              <= 1'b0;
      nc_pending           <= 1'b0;
      io_pending           <= 1'b0;
      rsp_valid            <= 1'b0;
      rsp_data             <= {DW{1'b0}};
      load_bus_error_trap  <= 1'b0;
      fetch_bus_error_trap <= 1'b0;
      atomic_space_trap    <= 1'b0;
      mem_valid            <= 1'b0;
      mem_write            <= 1'b0;
      mem_addr             <= {`PA_WIDTH{1'b0}};
      mem_wdata            <= {DW{1'b0}};
      mem_io               <= 1'b0;
    end else begin
      state                <= next_state;
      rsp_valid            <= 1'b0;
      load_bus_error_trap  <= 1'b0;
      fetch_bus_error_trap <= 1'b0;
      atomic_space_trap    <= 1'b0;
      if (take && op_bar)
        bar_mask <= req_bar_mask;
      if (take && (op_ld || op_fe || op_at)) begin
        ld_addr   <= eff_pa;
        ld_fetch  <= op_fe;
        ld_atomic <= op_at;
        ld_wdata  <= req_wdata;
        if (op_at && is_io) begin
          // atomics to i/o space are refused
          atomic_space_trap <= 1'b1;
          rsp_valid         <= 1'b1;
        end else if (!exists) begin
          load_bus_error_trap  <= !op_fe;
          fetch_bus_error_trap <= op_fe;
          rsp_valid            <= 1'b1;
        end else if (op_ld && sb_hit && !is_io) begin
          // forward the youngest older store to that address
          rsp_valid <= 1'b1;
          rsp_data  <= sb_data;
        end
      end
      // store drain path; stores to holes were never queued
      // an accepted store must drop mem_valid or it goes out twice
      if (st_issue && !sb_pop) begin
        mem_valid <= 1'b1;
        mem_write <= 1'b1;
        mem_addr  <= sb_head_addr;
        mem_wdata <= sb_head_data;
        mem_io    <= sb_head_io;
      end else if (state == ST_IDLE && next_state == ST_LOAD) begin
        mem_valid <= 1'b1;
        mem_write <= op_at;
        mem_addr  <= eff_pa;
        mem_wdata <= req_wdata;
        mem_io    <= is_io;
      end else if (mem_valid && mem_ready) begin
        mem_valid <= 1'b0;
      end
      if (sb_pop) begin
        st_busy    <= 1'b1;
        nc_pending <= sb_head_io;
        io_pending <= sb_head_io;
      end else if (st_busy && mem_visible) begin
        st_busy    <= 1'b0;
        nc_pending <= 1'b0;
        io_pending <= 1'b0;
      end
      if (state == ST_WAIT && ld_finish) begin
        rsp_valid <= 1'b1;
        rsp_data  <= mem_rdata;
        // loads and atomics report a missing target on the load trap, fetches on the fetch trap
        load_bus_error_trap  <= mem_error && !ld_fetch;
        fetch_bus_error_trap <= mem_error && ld_fetch;
      end
    end
  end
endmodule

// *** bench/lsu_partner.sv ***
// cache crossbar and i/o bridge model facing the ordering unit
`timescale 1ns/1ps
module lsu_partner (
  input  wire        clock,
  input  wire        nrst,
  input  wire        slow,
  input  wire        mem_valid,
  input  wire        mem_write,
  input  wire [39:0] mem_addr,
  output reg         mem_ready,
  output reg         mem_done,
  output reg         mem_visible,
  output reg         mem_error,
  output reg  [63:0] mem_rdata
);
  reg  [3:0]  cnt;
  reg         busy;
  reg         wr;
  reg  [39:0] addr;
  wire        due = cnt == (slow ? 4'h5 : 4'h0);
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      {mem_ready, mem_done, mem_visible, mem_error} <= 4'h0;
      {cnt, busy, wr, addr} <= '0;
      mem_rdata <= 64'h0;
    end else begin
      mem_ready   <= 1'b0;
      mem_done    <= 1'b0;
      mem_visible <= 1'b0;
      mem_error   <= 1'b0;
      // read lines float between answers, so never hold old data
      mem_rdata   <= ~mem_rdata;
      cnt         <= cnt + 4'h1;
      if (!busy && !(mem_valid && !mem_ready)) begin
        cnt <= 4'h0;
      end else if (due && !busy) begin
        mem_ready <= 1'b1;
        busy      <= 1'b1;
        wr        <= mem_write;
        addr      <= mem_addr;
        cnt       <= 4'h0;
      end else if (due) begin
        busy        <= 1'b0;
        cnt         <= 4'h0;
        mem_visible <= wr;
        mem_done    <= !wr;
        // reserved i/o block answers reads as nonexistent
        mem_error   <= !wr && addr[39] && addr[38:32] == 7'h01;
        mem_rdata   <= {24'h5A5A5A, addr};
      end
    end
  end
endmodule

// *** bench/lsu_order_checker_asserts.sv ***
// port assertions for the load/store ordering unit
`timescale 1ns/1ps
`include "lsu_order_defines.vh"
module lsu_order_checker #(
  parameter        DW      = 64,
  parameter [36:0] MEM_TOP = 37'h0
) (
  input wire          clock,
  input wire          nrst,
  input wire          req_valid,
  input wire          req_ready,
  input wire [2:0]    req_op,
  input wire [39:0]   req_pa,
  input wire [4:0]    req_bar_mask,
  input wire          rsp_valid,
  input wire [DW-1:0] rsp_data,
  input wire          load_bus_error_trap,
  input wire          fetch_bus_error_trap,
  input wire          atomic_space_trap,
  input wire [1:0]    memory_model_field,
  input wire          mem_valid,
  input wire          mem_ready,
  input wire          mem_write,
  input wire [39:0]   mem_addr,
  input wire          mem_io,
  input wire          mem_done,
  input wire          mem_visible,
  input wire [DW-1:0] mem_rdata,
  input wire          mem_error
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire       take = req_valid && req_ready;
  wire       gone = !req_pa[39] && req_pa[36:0] > MEM_TOP;
  wire       st_in = take && !gone && (req_op == `OP_STORE ||
                     req_op == `OP_ATOMIC && !req_pa[39]);
  reg  [7:0] sb_cnt;
  reg        io_pend;
  reg        st_fly;
  reg        bar_on;
  // dropped stores never turn visible, so they are not counted
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sb_cnt  <= 8'h00;
      io_pend <= 1'b0;
      st_fly  <= 1'b0;
      bar_on  <= 1'b0;
    end else begin
      bar_on  <= (bar_on || take && req_op == `OP_BARRIER &&
                  |(req_bar_mask & 5'h1A)) && !drained;
      sb_cnt  <= sb_cnt + {7'h00, st_in} - {7'h00, mem_visible};
      io_pend <= (io_pend || mem_valid && mem_ready && mem_io)
                 && !(mem_done || mem_visible);
      st_fly  <= (st_fly || mem_valid && mem_ready && mem_write)
                 && !mem_visible;
    end
  end
  wire drained = sb_cnt == 8'h00 || sb_cnt == 8'h01 && mem_visible;
  sequence load_ok_s;
    mem_done && !mem_error;
  endsequence
  sequence bad_s;
    take && gone;
  endsequence
  model_zero_a: assert property (memory_model_field == 2'h0)
    else $error("memory model field not zero");
  io_class_a: assert property (mem_valid |-> mem_io == mem_addr[39])
    else $error("i/o flag disagrees with address");
  alias_zero_a: assert property (
    mem_valid && !mem_addr[39] |-> mem_addr[38:37] == 2'b00)
    else $error("memory request alias bits not cleared");
  drop_store_a: assert property (
    mem_valid && mem_write && !mem_addr[39] |-> mem_addr[36:0] <= MEM_TOP)
    else $error("store to missing memory sent out");
  load_trap_a: assert property (
    bad_s ##0 req_op == `OP_LOAD |=> rsp_valid && load_bus_error_trap)
    else $error("missing load trap");
  fetch_trap_a: assert property (
    bad_s ##0 req_op == `OP_FETCH |=> rsp_valid && fetch_bus_error_trap)
    else $error("missing fetch trap");
  atomic_io_a: assert property (
    take && req_op == `OP_ATOMIC && req_pa[39] |=> atomic_space_trap)
    else $error("atomic to i/o not trapped");
  load_data_a: assert property (
    load_ok_s |=> rsp_valid && rsp_data == $past(mem_rdata))
    else $error("load answer wrong");
  io_error_a: assert property (
    mem_done && mem_error |=> rsp_valid &&
    (load_bus_error_trap || fetch_bus_error_trap))
    else $error("i/o error not trapped");
  io_order_a: assert property (io_pend |-> !(mem_valid && mem_io))
    else $error("i/o accesses overlap");
  store_order_a: assert property (st_fly |-> !(mem_valid && mem_write))
    else $error("store issued before older visible");
  barrier_wait_a: assert property (
    bar_on && !drained |-> !req_ready)
    else $error("barrier passed pending stores");
  io_load_wait_a: assert property (
    take && req_op == `OP_LOAD && req_pa[39] |-> drained)
    else $error("i/o load passed pending stores");
endmodule
bind load_store_ordering_unit lsu_order_checker #(
  .DW(DW), .MEM_TOP(MEM_TOP)) lsu_order_checker_inst (.*);

// *** bench/load_store_ordering_unit_test.sv ***
// self-checking bench for the load/store ordering unit
`timescale 1ns/1ps
`include "lsu_order_defines.vh"
module load_store_ordering_unit_test;
  localparam [36:0] TOP = 37'h00000FFFFF;
  localparam [23:0] TAG = 24'h5A5A5A;
  reg         clock = 0, nrst = 0, slow = 0, req_valid = 0;
  reg         req_relaxed = 0, req_side_effect = 0;
  reg  [2:0]  req_op = 0, got_t = 0;
  reg  [39:0] req_pa = 0;
  reg  [63:0] req_wdata = 0, got_d = 0, last_wd = 0;
  reg  [4:0]  req_bar_mask = 0;
  wire        req_ready, rsp_valid, lbe, fbe, ase, mem_valid, mem_write;
  wire        mem_io, mem_ready, mem_done, mem_visible, mem_error;
  wire [1:0]  mmf;
  wire [39:0] mem_addr;
  wire [63:0] rsp_data, mem_wdata, mem_rdata;
  integer     failures = 0, num_checks = 0, rsp_cnt = 0, vis = 0, cyc = 0;
  load_store_ordering_unit #(.MEM_TOP(TOP)) load_store_ordering_unit_inst (
    .clock(clock), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_va(48'h0),
    .req_pa(req_pa), .req_wdata(req_wdata), .req_relaxed(req_relaxed),
    .req_side_effect(req_side_effect), .req_bar_mask(req_bar_mask),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .load_bus_error_trap(lbe), .fetch_bus_error_trap(fbe),
    .atomic_space_trap(ase), .memory_model_field(mmf),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_io(mem_io),
    .mem_done(mem_done), .mem_visible(mem_visible),
    .mem_rdata(mem_rdata), .mem_error(mem_error));
  lsu_partner lsu_partner_inst (
    .clock(clock), .nrst(nrst), .slow(slow), .mem_valid(mem_valid),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_ready(mem_ready),
    .mem_done(mem_done), .mem_visible(mem_visible),
    .mem_error(mem_error), .mem_rdata(mem_rdata));
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (rsp_valid) begin
      rsp_cnt <= rsp_cnt + 1;
      got_d   <= rsp_data;
      got_t   <= {lbe, fbe, ase};
    end
    if (mem_visible) vis <= vis + 1;
    if (mem_valid && mem_ready && mem_write) last_wd <= mem_wdata;
    if (cyc == 3000) begin
      failures = failures + 1;
      test_done;
    end
  end
  task test_done;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task check(input [63:0] got, input [63:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task issue(input [2:0] op, input [39:0] pa, input [63:0] d,
             input [4:0] m);
    begin
      req_valid    <= 1'b1;
      req_op       <= op;
      req_pa       <= pa;
      req_wdata    <= d;
      req_bar_mask <= m;
      @(negedge clock);
      while (!req_ready) @(negedge clock);
      @(posedge clock);
      req_valid <= 1'b0;
      @(posedge clock);
    end
  endtask
  task ask(input [2:0] op, input [39:0] pa, input [63:0] e, input [2:0] t);
    integer n, k;
    begin
      n = rsp_cnt;
      issue(op, pa, 64'h0, 5'h00);
      for (k = 0; k < 200 && rsp_cnt == n; k = k + 1) @(negedge clock);
      check(64'(rsp_cnt - n), 64'h1);
      check(64'(got_t), 64'(t));
      if (t == 3'h0) check(got_d, e);
      @(posedge clock);
    end
  endtask
  // a barrier holds ready low until it has drained
  task drain;
    integer k;
    begin
      @(negedge clock);
      for (k = 0; k < 400 && !req_ready; k = k + 1) @(negedge clock);
      check(64'(req_ready), 64'h1);
      @(posedge clock);
    end
  endtask
  task t_mem_load;
    begin
      req_side_effect <= 1'b1;
      check(64'(mmf), 64'h0);
      ask(`OP_LOAD, 40'h6000001230, {TAG, 40'h0000001230}, 3'h0);
      ask(`OP_FETCH, 40'h0000002000, {TAG, 40'h0000002000}, 3'h0);
      req_side_effect <= 1'b0;
    end
  endtask
  task t_forward;
    integer v;
    begin
      slow <= 1'b1;
      v = vis;
      issue(`OP_STORE, 40'h0000000300, 64'h1111, 5'h00);
      issue(`OP_STORE, 40'h0000000300, 64'h2222, 5'h00);
      ask(`OP_LOAD, 40'h0000000300, 64'h2222, 3'h0);
      issue(`OP_BARRIER, 40'h0, 64'h0, 5'h02);
      drain;
      check(64'(vis), 64'(v + 2));
      check(last_wd, 64'h2222);
    end
  endtask
  task t_io;
    begin
      req_relaxed <= 1'b1;
      issue(`OP_STORE, 40'h8000000040, 64'h3333, 5'h00);
      issue(`OP_BARRIER, 40'h0, 64'h0, 5'h10);
      drain;
      ask(`OP_LOAD, 40'h8000000040, {TAG, 40'h8000000040}, 3'h0);
      ask(`OP_LOAD, 40'h8100000000, 64'h0, 3'h4);
      ask(`OP_FETCH, 40'h8100000000, 64'h0, 3'h2);
      req_relaxed <= 1'b0;
    end
  endtask
  task t_missing;
    integer v, n;
    begin
      v = vis;
      n = rsp_cnt;
      issue(`OP_STORE, 40'h0000100000, 64'h4444, 5'h00);
      issue(`OP_BARRIER, 40'h0, 64'h0, 5'h1A);
      drain;
      check(64'(vis), 64'(v));
      check(last_wd, 64'h3333);
      check(64'(rsp_cnt), 64'(n));
      ask(`OP_LOAD, 40'h0000100000, 64'h0, 3'h4);
      ask(`OP_FETCH, 40'h0000100008, 64'h0, 3'h2);
      ask(`OP_ATOMIC, 40'h8000000000, 64'h0, 3'h1);
      ask(`OP_ATOMIC, 40'h0000000500, {TAG, 40'h0000000500}, 3'h0);
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_mem_load;
    t_forward;
    t_io;
    t_missing;
    test_done;
  end
endmodule
